// ---- verilog/vertical_gate_timing_control.v ----
// vertical gate, field identifier, line clock enables and raw gain control
//
// Contract
// R01: gate rises at line of nine-bit start value, msb 17h bit 0, low 15h.
// R02: gate falls at line of nine-bit stop value, msb 17h bit 1, low 16h.
// R03: field identifier changes polarity at the gate start position.
// R04: value 312/262 is first line of field, 0 the next, per mode.
// R05: advance bit set moves the gate one line earlier in field two.
// R06: bit 7 zero drives line clock, one tri-states; bit 6 likewise half clock.
// R07: latency bits 5..3 give one to seven fields; 000 reserved; 011 recommended.
// R08: raw samples scaled by gain register; 128 nominal, 255 double, 0 off.
// R09: per-field line counter compared to start and stop, gate held between.
`timescale 1ns/100ps
`default_nettype none
`include "vertical_gate_map.vh"

module vertical_gate_timing_control #(
  parameter RAW_W = 8
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [7:0] reg_rdata_o,
  input wire line_start_i,
  input wire field_start_i,
  input wire field_second_i,
  input wire mode_60hz_i,
  input wire line_locked_clock_i,
  input wire half_line_locked_clock_i,
  input wire raw_valid_i,
  input wire [RAW_W-1:0] raw_sample_i,
  output reg vertical_gate_o,
  output reg field_identifier_o,
  output reg line_locked_clock_o,
  output wire line_locked_clock_oe_n_o,
  output reg half_line_locked_clock_o,
  output wire half_line_locked_clock_oe_n_o,
  output wire [2:0] search_loop_latency_o,
  output wire search_step_o,
  output wire raw_valid_o,
  output wire [RAW_W:0] raw_sample_o
);
  // *************************************************************
  // registers
  // *************************************************************
  reg [7:0] gate_start_low_byte;
  reg [7:0] gate_stop_low_byte;
  reg [7:0] misc_gate_high_bits;
  reg [7:0] raw_sample_gain;
  reg [7:0] next_rdata;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      gate_start_low_byte <= `VG_RST_START_LOW;
      gate_stop_low_byte <= `VG_RST_STOP_LOW;
      misc_gate_high_bits <= `VG_RST_MISC_HIGH;
      raw_sample_gain <= `VG_RST_RAW_GAIN;
    end else if (ce_i && reg_write_i) begin
      case (reg_addr_i)
        `VG_ADDR_START_LOW: begin
          gate_start_low_byte <= reg_wdata_i;
        end
        `VG_ADDR_STOP_LOW: begin
          gate_stop_low_byte <= reg_wdata_i;
        end
        `VG_ADDR_MISC_HIGH: begin
          misc_gate_high_bits <= reg_wdata_i;
        end
        `VG_ADDR_RAW_GAIN: begin
          raw_sample_gain <= reg_wdata_i;
        end
        default: begin
          gate_start_low_byte <= gate_start_low_byte;
        end
      endcase
    end
  end

  // unmapped subaddresses read as zero
  always @* begin
    case (reg_addr_i)
      `VG_ADDR_START_LOW: next_rdata = gate_start_low_byte;
      `VG_ADDR_STOP_LOW: next_rdata = gate_stop_low_byte;
      `VG_ADDR_MISC_HIGH: next_rdata = misc_gate_high_bits;
      `VG_ADDR_RAW_GAIN: next_rdata = raw_sample_gain;
      default: next_rdata = `VG_RST_READ_DATA;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= `VG_RST_READ_DATA;
    end else if (ce_i && reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // *************************************************************
  // line counting and gate
  // *************************************************************
  wire [8:0] start_value;
  wire [8:0] stop_value;
  wire [8:0] field_top;
  wire advance;
  reg [8:0] line_count;
  reg [8:0] compare_count;

  assign start_value = {misc_gate_high_bits[`VG_BIT_START_MSB], gate_start_low_byte}; // see R01
  assign stop_value = {misc_gate_high_bits[`VG_BIT_STOP_MSB], gate_stop_low_byte}; // see R02
  assign field_top = mode_60hz_i ? `VG_FIELD_TOP_60HZ : `VG_FIELD_TOP_50HZ;
  assign advance = misc_gate_high_bits[`VG_BIT_FIELD2_ADV] && field_second_i;

  // advanced gate looks one count ahead, so it fires one line earlier (see R05)
  always @* begin
    compare_count = line_count;
    if (advance) begin
      if (line_count == field_top) begin
        compare_count = 9'h000;
      end else begin
        compare_count = line_count + 9'h001;
      end
    end
  end

  // field start line holds the top value, the following line is value 0 (see R04)
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      line_count <= 9'h000;
    end else if (ce_i) begin
      if (field_start_i) begin
        line_count <= field_top; // see R04
      end else if (line_start_i) begin
        if (line_count >= field_top) begin
          line_count <= 9'h000;
        end else begin
          line_count <= line_count + 9'h001; // see R09
        end
      end
    end
  end

  // evaluated once per line; stop wins when both values are equal
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      vertical_gate_o <= 1'b0;
      field_identifier_o <= 1'b0;
    end else if (ce_i && (line_start_i || field_start_i)) begin
      if (compare_count == stop_value) begin
        vertical_gate_o <= 1'b0; // see R02
      end else if (compare_count == start_value) begin
        vertical_gate_o <= 1'b1; // see R01
      end else begin
        vertical_gate_o <= vertical_gate_o; // see R09
      end
      if (compare_count == start_value) begin
        field_identifier_o <= field_second_i; // see R03
      end
    end
  end

  // *************************************************************
  // line clock outputs
  // *************************************************************
  // enable is active low: register bit zero means the pin is driven
  assign line_locked_clock_oe_n_o = misc_gate_high_bits[`VG_BIT_LINE_CLK_OFF]; // see R06
  assign half_line_locked_clock_oe_n_o = misc_gate_high_bits[`VG_BIT_HALF_LINE_CLK_OFF]; // see R06

  // retimed by one cycle, the trade for a flip-flop driven pin
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      line_locked_clock_o <= 1'b0;
      half_line_locked_clock_o <= 1'b0;
    end else if (ce_i) begin
      line_locked_clock_o <= line_locked_clock_i;
      half_line_locked_clock_o <= half_line_locked_clock_i;
    end
  end

  // *************************************************************
  // search latency and raw gain
  // *************************************************************
  search_latency_pacer u_pacer (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .field_start_i(field_start_i),
    .latency_code_i(misc_gate_high_bits[`VG_LATENCY_MSB:`VG_LATENCY_LSB]),
    .latency_fields_o(search_loop_latency_o),
    .search_step_o(search_step_o)
  );

  raw_gain_scaler #(
    .DATA_W(RAW_W)
  ) u_gain (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .sample_valid_i(raw_valid_i),
    .sample_i(raw_sample_i),
    .gain_i(raw_sample_gain),
    .sample_valid_o(raw_valid_o),
    .sample_o(raw_sample_o)
  );
endmodule
`default_nettype wire

// ---- verilog/vertical_gate_map.vh ----
// register offsets, field positions, reset values and line figures of the vertical gate block
`ifndef VERTICAL_GATE_MAP_VH
`define VERTICAL_GATE_MAP_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define VG_ADDR_START_LOW 8'h15
`define VG_ADDR_STOP_LOW 8'h16
`define VG_ADDR_MISC_HIGH 8'h17
`define VG_ADDR_RAW_GAIN 8'h18

// ***************************************************************
// fields of misc_gate_high_bits
// ***************************************************************
`define VG_BIT_START_MSB 0
`define VG_BIT_STOP_MSB 1
`define VG_BIT_FIELD2_ADV 2
`define VG_LATENCY_LSB 3
`define VG_LATENCY_MSB 5
`define VG_BIT_HALF_LINE_CLK_OFF 6
`define VG_BIT_LINE_CLK_OFF 7

// ***************************************************************
// reset values
// ***************************************************************
`define VG_RST_START_LOW 8'h00
`define VG_RST_STOP_LOW 8'h00
`define VG_RST_MISC_HIGH 8'h18
`define VG_RST_RAW_GAIN 8'h80
`define VG_RST_READ_DATA 8'h00

// ***************************************************************
// line figures, latency codes and gain shift
// ***************************************************************
`define VG_FIELD_TOP_50HZ 9'h138
`define VG_FIELD_TOP_60HZ 9'h106
`define VG_LATENCY_RESERVED 3'h0
`define VG_LATENCY_FALLBACK 3'h3
`define VG_GAIN_SHIFT 7

`endif

// ---- verilog/search_latency_pacer.v ----
// paces the colour standard search loop by a programmed number of fields
`timescale 1ns/100ps
`default_nettype none
`include "vertical_gate_map.vh"

module search_latency_pacer (
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  input wire field_start_i,
  input wire [2:0] latency_code_i,
  output reg [2:0] latency_fields_o,
  output reg search_step_o
);
  reg [2:0] field_count;
  wire [2:0] eff_latency;

  // reserved code falls back to the recommended three fields, never zero (see R07)
  assign eff_latency = (latency_code_i == `VG_LATENCY_RESERVED) ? `VG_LATENCY_FALLBACK : latency_code_i;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      field_count <= 3'h0;
      latency_fields_o <= `VG_LATENCY_FALLBACK;
      search_step_o <= 1'b0;
    end else if (ce_i) begin
      latency_fields_o <= eff_latency;
      search_step_o <= 1'b0;
      if (field_start_i) begin
        if (field_count + 3'h1 >= eff_latency) begin
          field_count <= 3'h0;
          search_step_o <= 1'b1; // see R07
        end else begin
          field_count <= field_count + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/raw_gain_scaler.v ----
// scales raw samples by the eight-bit gain, 128 nominal
`timescale 1ns/100ps
`default_nettype none
`include "vertical_gate_map.vh"

module raw_gain_scaler #(
  parameter DATA_W = 8
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  input wire sample_valid_i,
  input wire [DATA_W-1:0] sample_i,
  input wire [7:0] gain_i,
  output reg sample_valid_o,
  output reg [DATA_W:0] sample_o
);
  wire [DATA_W+7:0] product;

  // one extra output bit so double amplitude never clips
  assign product = sample_i * gain_i;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sample_valid_o <= 1'b0;
      sample_o <= {(DATA_W+1){1'b0}};
    end else if (ce_i) begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        sample_o <= product[DATA_W+`VG_GAIN_SHIFT:`VG_GAIN_SHIFT]; // see R08
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/vertical_gate_props.sv ----
// port assertions for the vertical gate block
`timescale 1ns/100ps
`default_nettype none
module vertical_gate_props (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic line_start_i,
  input wire logic field_start_i,
  input wire logic field_second_i,
  input wire logic line_locked_clock_i,
  input wire logic half_line_locked_clock_i,
  input wire logic raw_valid_i,
  input wire logic vertical_gate_o,
  input wire logic field_identifier_o,
  input wire logic line_locked_clock_o,
  input wire logic line_locked_clock_oe_n_o,
  input wire logic half_line_locked_clock_o,
  input wire logic [2:0] search_loop_latency_o,
  input wire logic search_step_o,
  input wire logic raw_valid_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  chk_line_clock_copy: assert property (ce_i |=> line_locked_clock_o == $past(line_locked_clock_i))
    else $error("line clock copy wrong");
  chk_raw_valid_delay: assert property (ce_i |=> raw_valid_o == $past(raw_valid_i))
    else $error("raw valid delay wrong");
  chk_latency_not_zero: assert property (search_loop_latency_o != 3'h0)
    else $error("latency reports reserved code");
  chk_step_one_cycle: assert property (search_step_o |=> !search_step_o)
    else $error("search step too long");
  chk_gate_on_line: assert property (!$past(reset_i) && $changed(vertical_gate_o) |->
    $past(line_start_i || field_start_i)) else $error("gate moved off a line edge");
  chk_field_id_start: assert property (!$past(reset_i) && $changed(field_identifier_o) |->
    $past(line_start_i || field_start_i) && field_identifier_o == $past(field_second_i))
    else $error("field identifier wrong");
  chk_rdata_on_read: assert property (!$past(reset_i) && $changed(reg_rdata_o) |-> $past(reg_read_i))
    else $error("read data moved without read");
  chk_oe_after_reset: assert property ($fell(reset_i) |-> !line_locked_clock_oe_n_o)
    else $error("line clock not driven after reset");
  chk_half_clock_copy: assert property (ce_i |=> half_line_locked_clock_o == $past(half_line_locked_clock_i))
    else $error("half line clock copy wrong");
  chk_step_after_field: assert property ($rose(search_step_o) |-> $past(field_start_i))
    else $error("search step without field start");
  // a low enable must freeze the gate and the retimed clock alike
  chk_freeze_hold: assert property (!ce_i |=> $stable(vertical_gate_o) && $stable(line_locked_clock_o))
    else $error("state moved while frozen");
endmodule
bind vertical_gate_timing_control vertical_gate_props chk_i (.clk_sys_i, .reset_i, .ce_i, .reg_read_i,
  .reg_rdata_o, .line_start_i, .field_start_i, .field_second_i, .line_locked_clock_i, .half_line_locked_clock_i,
  .raw_valid_i, .vertical_gate_o, .field_identifier_o, .line_locked_clock_o, .line_locked_clock_oe_n_o,
  .half_line_locked_clock_o, .search_loop_latency_o, .search_step_o, .raw_valid_o);
`default_nettype wire

// ---- testbench/vertical_gate_timing_control_test.sv ----
// self-checking bench for the vertical gate block
`timescale 1ns/100ps
`default_nettype none
module vertical_gate_timing_control_test;
  logic clk_sys_i = 0, reset_i = 1, ce = 1, wr = 0, rd = 0, ls = 0, fs = 0, f2 = 0, m60 = 0, lc = 0, hc = 0, rv = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, smp = 8'h00, rdata, rd8;
  logic gate, fld_id, lco, hco, oe, oe2, step, rvo, adv = 0, eg = 0, ef = 0, es = 0, lc_d = 0, hc_d = 0;
  logic [2:0] lat;
  logic [8:0] rso, sta, sto, top, cnt = 9'h000, cv;
  logic [23:0] rows [5] = '{24'h15A5A5, 24'h165A5A, 24'h17C7C7, 24'h18FFFF, 24'h197700};
  logic [16:0] gains [3] = '{17'h1FF8E, 17'h100C8, 17'h00000};
  logic [7:0] rst [4] = '{8'h00, 8'h00, 8'h18, 8'h80};
  int miscompares = 0, checks_done = 0, cyc = 0, nf = 0;
  // ****************
  // clock, line clocks, watchdog
  // ****************
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    lc <= ~lc;
    hc <= lc ? ~hc : hc;
    lc_d <= lc;
    hc_d <= hc;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  vertical_gate_timing_control dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .line_start_i(ls),
    .field_start_i(fs), .field_second_i(f2), .mode_60hz_i(m60), .line_locked_clock_i(lc),
    .half_line_locked_clock_i(hc), .raw_valid_i(rv), .raw_sample_i(smp), .vertical_gate_o(gate),
    .field_identifier_o(fld_id), .line_locked_clock_o(lco), .line_locked_clock_oe_n_o(oe),
    .half_line_locked_clock_o(hco), .half_line_locked_clock_oe_n_o(oe2), .search_loop_latency_o(lat),
    .search_step_o(step), .raw_valid_o(rvo), .raw_sample_o(rso));
  task automatic chk(input logic [8:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk_sys_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    rd8 = rdata;
  endtask
  // model compares the count held before each line edge
  task automatic line(input logic first);
    @(posedge clk_sys_i);
    fs <= first;
    ls <= ~first;
    @(posedge clk_sys_i);
    fs <= 1'b0;
    ls <= 1'b0;
    cv = (adv && f2) ? (cnt == top ? 9'h000 : cnt + 9'h001) : cnt;
    if (cv == sto) eg = 1'b0;
    else if (cv == sta) begin
      eg = 1'b1;
      ef = f2;
    end
    // every field scenario programs the recommended three-field latency
    es = first && (nf == 2);
    nf = first ? (nf == 2 ? 0 : nf + 1) : nf;
    cnt = first ? top : (cnt == top ? 9'h000 : cnt + 9'h001);
    @(negedge clk_sys_i);
    chk({8'h00, gate}, {8'h00, eg});
    chk({8'h00, fld_id}, {8'h00, ef});
    chk({8'h00, step}, {8'h00, es});
    chk({7'h00, lco, hco}, {7'h00, lc_d, hc_d});
  endtask
  task automatic field(input logic m, s, a, input logic [8:0] st, sp);
    @(posedge clk_sys_i);
    m60 <= m;
    f2 <= s;
    wreg(8'h15, st[7:0]);
    wreg(8'h16, sp[7:0]);
    wreg(8'h17, {5'h03, a, sp[8], st[8]});
    {adv, sta, sto, top} = {a, st, sp, m ? 9'h106 : 9'h138};
    line(1'b1);
    repeat (9) line(1'b0);
    $display("field test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      wreg(rows[i][23:16], rows[i][15:8]);
      rreg(rows[i][23:16]);
      chk({1'b0, rd8}, {1'b0, rows[i][7:0]});
    end
    $display("register test done");
    for (int c = 0; c < 8; c++) begin
      wreg(8'h17, {c[0], c[1], c[2:0], 3'h0});
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      chk({4'h0, oe, oe2, lat}, {4'h0, c[0], c[1], c == 0 ? 3'h3 : c[2:0]});
    end
    $display("latency test done");
    foreach (gains[i]) begin
      wreg(8'h18, gains[i][16:9]);
      @(posedge clk_sys_i);
      smp <= 8'hC8;
      rv <= 1'b1;
      @(posedge clk_sys_i);
      rv <= 1'b0;
      @(negedge clk_sys_i);
      chk(rso, gains[i][8:0]);
    end
    $display("gain test done");
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    foreach (rst[i]) begin
      rreg(8'h15 + i[7:0]);
      chk({1'b0, rd8}, {1'b0, rst[i]});
    end
    chk({4'h0, oe, oe2, lat}, 9'h003);
    $display("reset test done");
    @(posedge clk_sys_i);
    ce <= 1'b0;
    wreg(8'h18, 8'h00);
    ce <= 1'b1;
    rreg(8'h18);
    chk({1'b0, rd8}, 9'h080);
    $display("clock enable test done");
    field(1'b0, 1'b0, 1'b0, 9'h002, 9'h005);
    field(1'b0, 1'b1, 1'b1, 9'h002, 9'h005);
    field(1'b1, 1'b0, 1'b0, 9'h106, 9'h000);
    field(1'b0, 1'b1, 1'b0, 9'h138, 9'h136);
    wrap_up();
  end
endmodule
`default_nettype wire
